// *** verilog/ops_map.svh ***
`ifndef OPS_MAP_SVH
`define OPS_MAP_SVH

// command codes on the serial link
`define OPS_CMD_READ_ANGLE 5'h00
`define OPS_CMD_STATUS 5'h04
`define OPS_CMD_PROBE 5'h09
`define OPS_CMD_READ_FUSE 5'h0F
`define OPS_CMD_EXT_ENTER 5'h10
`define OPS_CMD_BURN 5'h19
`define OPS_CMD_SOFT_WRITE 5'h1F

// customer fuse word layout
`define OPS_CUST_W 21
`define OPS_ZERO_MSB 8
`define OPS_ZERO_LSB 0
`define OPS_POLE_MSB 11
`define OPS_POLE_LSB 9
`define OPS_INC_MSB 13
`define OPS_INC_LSB 12
`define OPS_SENS_MSB 15
`define OPS_SENS_LSB 14
`define OPS_SPARE_BIT 16
`define OPS_SPARE_ADDR_MSB 20
`define OPS_SPARE_ADDR_LSB 17
`define OPS_SPARE_REGION 5'h10

// whole fuse bank, customer part in the low bits
`define OPS_FUSE_W 62
`define OPS_FACTORY_W 41
// factory part after reset; value is arbitrary
`define OPS_FACTORY_DEFAULT 41'h000_0000_0000

// link frame figures
`define OPS_CMD_LAST 6'h04
`define OPS_WDATA_LAST 6'h14
`define OPS_PROBE_LAST 6'h3D
`define OPS_LEN_FUSE 6'h15
`define OPS_LEN_STATUS 6'h01
`define OPS_LEN_ANGLE 6'h10
`define OPS_EXT_LAST_SLOT 2'h3

`endif

// *** verilog/ops_pkg.sv ***
package ops_pkg;
   // frame state of the serial link
   typedef enum logic [2:0] {L_CMD, L_WDATA, L_RDATA, L_PROBE, L_DONE} ops_lstate_t;
   // five-bit command code
   typedef logic [4:0] ops_cmd_t;
endpackage

// *** verilog/ops_sync.sv ***
`timescale 1ns/1ps
// two-stage synchroniser; only the second stage leaves the module
module ops_sync
   (
   // destination clock
   input wire logic clk,
   // asynchronous level in, synchronised level out
   input wire logic d,
   output logic q
   );
   logic meta_r;

   // no reset: a settled input reaches q within two edges
   always_ff @(posedge clk)
   begin
      meta_r <= d;
      q <= meta_r;
   end
endmodule // ops_sync

// *** verilog/ops_core.sv ***
`timescale 1ns/1ps
`include "ops_map.svh"

module ops_core
   import ops_pkg::*;
   (
   // system clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // serial link
   input wire logic LINK_CLK,
   input wire logic CS,
   input wire logic DIO_IN,
   output logic DIO_OUT,
   output logic DIO_OE,
   // fuse supply pin, also the probe output
   input wire logic FUSE_SUPPLY_OK,
   output logic FUSE_SUPPLY_PIN_OUT,
   output logic FUSE_SUPPLY_PIN_OE,
   // angle front end, same clock
   input wire logic LOCK_IN,
   input wire logic [5:0] GAIN_CONTROL_LEVEL,
   input wire logic [8:0] ANGLE_IN,
   // applied configuration
   output logic [8:0] ZERO_OFFSET_FIELD,
   output logic [2:0] POLE_SEL,
   output logic [1:0] INC_MODE,
   output logic [1:0] GAIN_SENS,
   // status
   output logic TRACK_VALID,
   output logic EXT_MODE,
   output logic FUSE_ERR
   );

   // spare substitution, only for the customer region
   function automatic logic [20:0] spare_fix(input logic [20:0] w);
      logic [4:0] redundancy_address;
      begin
         redundancy_address = {1'b0, w[`OPS_SPARE_ADDR_MSB:`OPS_SPARE_ADDR_LSB]};
         spare_fix = w;
         if (w[`OPS_SPARE_BIT] && redundancy_address < `OPS_SPARE_REGION)
         begin
            spare_fix[redundancy_address[3:0]] = 1'b1;
         end
      end
   endfunction

   // core state
   logic ext_r, ext_nxt; // extended mode, sticky until reset
   logic [20:0] soft_r, soft_nxt; // working customer word
   logic [61:0] fuse_r, fuse_nxt; // fuse bank
   logic err_r, err_nxt; // readback error flag
   logic [20:0] eff_r, eff_nxt; // word after spare fix
   logic start_r, start_nxt; // start angle captured
   logic [8:0] ang0_r, ang0_nxt; // angle at startup
   logic moved_r, moved_nxt; // magnet has turned
   logic track_r, track_nxt; // tracking valid
   logic req_prev_r, req_prev_nxt; // last seen request toggle
   // snapshot toward the link
   logic [61:0] snap_fuse_r, snap_fuse_nxt;
   logic [20:0] snap_soft_r, snap_soft_nxt;
   logic [17:0] snap_stat_r, snap_stat_nxt; // err, ext, track, gain, angle
   logic snap_tgl_r, snap_tgl_nxt;
   // crossings
   logic req_s; // request toggle in core domain
   logic ack_s; // snapshot ack in core domain
   logic hv_s; // supply level in core domain
   logic link_rst; // reset in link domain
   logic snap_s; // snapshot toggle in link domain
   logic req_new; // one new link command
   logic [20:0] burn_word; // customer part of the bank after a burn

   // link state, persistent group
   logic req_tgl_r, req_tgl_nxt;
   logic [4:0] xfer_cmd_r, xfer_cmd_nxt;
   logic [20:0] xfer_data_r, xfer_data_nxt;
   logic ack_tgl_r, ack_tgl_nxt;
   logic [61:0] ls_fuse_r, ls_fuse_nxt;
   logic [20:0] ls_soft_r, ls_soft_nxt;
   logic [17:0] ls_stat_r, ls_stat_nxt;
   // link state, frame group
   ops_lstate_t st_r, st_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [5:0] len_r, len_nxt;
   logic [1:0] slot_r, slot_nxt;
   logic [4:0] cmd_r, cmd_nxt;
   logic [20:0] wsr_r, wsr_nxt;
   logic [61:0] osr_r, osr_nxt;
   logic load_req; // frame hands a command over
   ops_cmd_t load_cmd;
   logic [20:0] load_data;
   logic last_slot; // this edge ends a data bit
   logic ext_l; // extended mode seen by the link

   ops_sync u_req (.clk(CLK), .d(req_tgl_r), .q(req_s));
   ops_sync u_ack (.clk(CLK), .d(ack_tgl_r), .q(ack_s));
   ops_sync u_hv (.clk(CLK), .d(FUSE_SUPPLY_OK), .q(hv_s));
   ops_sync u_lrst (.clk(LINK_CLK), .d(SYS_RST), .q(link_rst));
   ops_sync u_snap (.clk(LINK_CLK), .d(snap_tgl_r), .q(snap_s));

   assign req_new = req_s != req_prev_r;
   assign burn_word = fuse_r[20:0] | xfer_data_r;

   // core next state: commands, spare fix, tracking, snapshot
   always_comb
   begin
      ext_nxt = ext_r;
      soft_nxt = soft_r;
      fuse_nxt = fuse_r;
      err_nxt = err_r;
      req_prev_nxt = req_s;
      start_nxt = 1'b1;
      ang0_nxt = start_r ? ang0_r : ANGLE_IN;
      // any step away from the start angle is about one degree
      moved_nxt = moved_r | (start_r && ANGLE_IN != ang0_r);
      // gain level is not looked at here, only lock and motion
      track_nxt = LOCK_IN & moved_r;
      eff_nxt = spare_fix(soft_r);
      if (req_new)
      begin
         case (xfer_cmd_r)
            `OPS_CMD_EXT_ENTER: ext_nxt = 1'b1;
            `OPS_CMD_SOFT_WRITE:
            begin
               // volatile: zero offset and sensitivity alike
               if (ext_r)
                  soft_nxt = xfer_data_r;
            end
            `OPS_CMD_BURN:
            begin
               if (ext_r && hv_s)
               begin
                  // fuses only go from 0 to 1
                  fuse_nxt[20:0] = burn_word;
                  soft_nxt = burn_word;
                  err_nxt = burn_word != xfer_data_r;
               end
               else if (ext_r)
               begin
                  // no supply: nothing burned, flag the failure
                  err_nxt = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // reload the snapshot once the link has taken the last one
      snap_tgl_nxt = snap_tgl_r;
      snap_fuse_nxt = snap_fuse_r;
      snap_soft_nxt = snap_soft_r;
      snap_stat_nxt = snap_stat_r;
      if (ack_s == snap_tgl_r)
      begin
         snap_tgl_nxt = ~snap_tgl_r;
         snap_fuse_nxt = fuse_r;
         snap_soft_nxt = soft_r;
         snap_stat_nxt = {err_r, ext_r, track_r, GAIN_CONTROL_LEVEL, ANGLE_IN};
      end
   end

   // core registers
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         ext_r <= 1'b0;
         soft_r <= 21'h0_0000;
         fuse_r <= {`OPS_FACTORY_DEFAULT, 21'h0_0000};
         err_r <= 1'b0;
         eff_r <= 21'h0_0000;
         start_r <= 1'b0;
         ang0_r <= 9'h000;
         moved_r <= 1'b0;
         track_r <= 1'b0;
         req_prev_r <= 1'b0;
         snap_tgl_r <= 1'b0;
         snap_fuse_r <= 62'h0;
         snap_soft_r <= 21'h0_0000;
         snap_stat_r <= 18'h0_0000;
      end
      else
      begin
         ext_r <= ext_nxt;
         soft_r <= soft_nxt;
         fuse_r <= fuse_nxt;
         err_r <= err_nxt;
         eff_r <= eff_nxt;
         start_r <= start_nxt;
         ang0_r <= ang0_nxt;
         moved_r <= moved_nxt;
         track_r <= track_nxt;
         req_prev_r <= req_prev_nxt;
         snap_tgl_r <= snap_tgl_nxt;
         snap_fuse_r <= snap_fuse_nxt;
         snap_soft_r <= snap_soft_nxt;
         snap_stat_r <= snap_stat_nxt;
      end
   end

   // applied fields, all from flops
   assign ZERO_OFFSET_FIELD = eff_r[`OPS_ZERO_MSB:`OPS_ZERO_LSB];
   assign POLE_SEL = eff_r[`OPS_POLE_MSB:`OPS_POLE_LSB];
   assign INC_MODE = eff_r[`OPS_INC_MSB:`OPS_INC_LSB];
   assign GAIN_SENS = eff_r[`OPS_SENS_MSB:`OPS_SENS_LSB];
   assign TRACK_VALID = track_r;
   assign EXT_MODE = ext_r;
   assign FUSE_ERR = err_r;

   // link persistent next state: request hand-over, snapshot take
   always_comb
   begin
      req_tgl_nxt = req_tgl_r;
      xfer_cmd_nxt = xfer_cmd_r;
      xfer_data_nxt = xfer_data_r;
      if (load_req)
      begin
         // held until the next command, long after the core read it
         req_tgl_nxt = ~req_tgl_r;
         xfer_cmd_nxt = load_cmd;
         xfer_data_nxt = load_data;
      end
      ack_tgl_nxt = ack_tgl_r;
      ls_fuse_nxt = ls_fuse_r;
      ls_soft_nxt = ls_soft_r;
      ls_stat_nxt = ls_stat_r;
      // never mid-frame, so a reply stays coherent
      if (snap_s != ack_tgl_r && (!CS || st_r == L_DONE))
      begin
         ack_tgl_nxt = snap_s;
         ls_fuse_nxt = snap_fuse_r;
         ls_soft_nxt = snap_soft_r;
         ls_stat_nxt = snap_stat_r;
      end
   end

   // link persistent registers
   always_ff @(posedge LINK_CLK)
   begin
      if (link_rst)
      begin
         req_tgl_r <= 1'b0;
         xfer_cmd_r <= 5'h00;
         xfer_data_r <= 21'h0_0000;
         ack_tgl_r <= 1'b0;
         ls_fuse_r <= 62'h0;
         ls_soft_r <= 21'h0_0000;
         ls_stat_r <= 18'h0_0000;
      end
      else
      begin
         req_tgl_r <= req_tgl_nxt;
         xfer_cmd_r <= xfer_cmd_nxt;
         xfer_data_r <= xfer_data_nxt;
         ack_tgl_r <= ack_tgl_nxt;
         ls_fuse_r <= ls_fuse_nxt;
         ls_soft_r <= ls_soft_nxt;
         ls_stat_r <= ls_stat_nxt;
      end
   end

   assign ext_l = ls_stat_r[16];
   assign last_slot = !ext_l || slot_r == `OPS_EXT_LAST_SLOT;

   // link frame next state
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      len_nxt = len_r;
      slot_nxt = slot_r;
      cmd_nxt = cmd_r;
      wsr_nxt = wsr_r;
      osr_nxt = osr_r;
      load_req = 1'b0;
      load_cmd = cmd_r;
      load_data = wsr_r;
      case (st_r)
         L_CMD:
         begin
            cmd_nxt = {cmd_r[3:0], DIO_IN};
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == `OPS_CMD_LAST)
            begin
               cnt_nxt = 6'h00;
               st_nxt = L_DONE;
               if (cmd_nxt == `OPS_CMD_SOFT_WRITE || cmd_nxt == `OPS_CMD_BURN)
               begin
                  if (ext_l)
                     st_nxt = L_WDATA;
               end
               else if (cmd_nxt == `OPS_CMD_READ_FUSE && ext_l)
               begin
                  osr_nxt = {ls_soft_r, 41'h0};
                  len_nxt = `OPS_LEN_FUSE;
                  st_nxt = L_RDATA;
               end
               else if (cmd_nxt == `OPS_CMD_PROBE && ext_l)
               begin
                  osr_nxt = ls_fuse_r;
                  st_nxt = L_PROBE;
               end
               else if (cmd_nxt == `OPS_CMD_EXT_ENTER)
               begin
                  load_req = 1'b1;
                  load_cmd = cmd_nxt;
               end
               else if (cmd_nxt == `OPS_CMD_STATUS)
               begin
                  osr_nxt = {ls_stat_r[17], 61'h0};
                  len_nxt = `OPS_LEN_STATUS;
                  st_nxt = L_RDATA;
               end
               else if (cmd_nxt == `OPS_CMD_READ_ANGLE)
               begin
                  // tracking flag, gain level, angle, msb first
                  osr_nxt = {ls_stat_r[15:0], 46'h0};
                  len_nxt = `OPS_LEN_ANGLE;
                  st_nxt = L_RDATA;
               end
            end
         end
         L_WDATA:
         begin
            // sample on the last of the four clocks of a bit
            slot_nxt = last_slot ? 2'h0 : slot_r + 2'h1;
            if (last_slot)
            begin
               wsr_nxt = {wsr_r[19:0], DIO_IN};
               cnt_nxt = cnt_r + 6'h01;
               if (cnt_r == `OPS_WDATA_LAST)
               begin
                  load_req = 1'b1;
                  load_data = wsr_nxt;
                  st_nxt = L_DONE;
               end
            end
         end
         L_RDATA:
         begin
            slot_nxt = last_slot ? 2'h0 : slot_r + 2'h1;
            if (last_slot)
            begin
               osr_nxt = {osr_r[60:0], 1'b0};
               cnt_nxt = cnt_r + 6'h01;
               if (cnt_r == len_r - 6'h01)
                  st_nxt = L_DONE;
            end
         end
         L_PROBE:
         begin
            // one fuse per clock, top bit first
            osr_nxt = {osr_r[60:0], 1'b0};
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == `OPS_PROBE_LAST)
               st_nxt = L_DONE;
         end
         default: ;
      endcase
   end

   // frame registers; chip select low ends any frame at once
   always_ff @(posedge LINK_CLK or negedge CS)
   begin
      if (!CS)
      begin
         st_r <= L_CMD;
         cnt_r <= 6'h00;
         len_r <= 6'h00;
         slot_r <= 2'h0;
         cmd_r <= 5'h00;
         wsr_r <= 21'h0_0000;
         osr_r <= 62'h0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         len_r <= len_nxt;
         slot_r <= slot_nxt;
         cmd_r <= cmd_nxt;
         wsr_r <= wsr_nxt;
         osr_r <= osr_nxt;
      end
   end

   // pins: data from the shift flop, enables from the state
   assign DIO_OUT = osr_r[61];
   assign DIO_OE = st_r == L_RDATA;
   // programmed fuse pulls low, as the analog probe reads it
   assign FUSE_SUPPLY_PIN_OUT = ~osr_r[61] & (st_r == L_PROBE);
   assign FUSE_SUPPLY_PIN_OE = st_r == L_PROBE;

   // checks
   AST_SOFT_WRITE: assert property (@(posedge CLK) disable iff (SYS_RST)
      req_new && ext_r && xfer_cmd_r == `OPS_CMD_SOFT_WRITE |=> soft_r == $past(xfer_data_r))
      else $error("soft write did not load the working word");
   AST_WRITE_GATED: assert property (@(posedge LINK_CLK) disable iff (!CS || link_rst)
      st_r == L_CMD && !ext_l && load_req |-> load_cmd == `OPS_CMD_EXT_ENTER)
      else $error("fuse command handed over outside extended mode");
   AST_BURN_NO_SUPPLY: assert property (@(posedge CLK) disable iff (SYS_RST)
      req_new && ext_r && !hv_s && xfer_cmd_r == `OPS_CMD_BURN |=> err_r && $stable(fuse_r))
      else $error("burn without supply not flagged");
   AST_FUSE_ONE_WAY: assert property (@(posedge CLK) disable iff (SYS_RST)
      ($past(fuse_r) & ~fuse_r) == 62'h0)
      else $error("a fuse returned to zero");
   AST_SPARE_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
      $past(soft_r[`OPS_SPARE_BIT]) |->
      eff_r[$past(soft_r[`OPS_SPARE_ADDR_MSB:`OPS_SPARE_ADDR_LSB])])
      else $error("spare value not applied");
   AST_SPARE_REGION: assert property (@(posedge CLK) disable iff (SYS_RST)
      eff_r[20:16] == $past(soft_r[20:16]))
      else $error("spare touched bits outside the customer region");
   AST_TRACK_START: assert property (@(posedge CLK) disable iff (SYS_RST)
      !moved_r |=> !track_r)
      else $error("tracking flag set before any rotation");
   AST_TRACK_EXTREME: assert property (@(posedge CLK) disable iff (SYS_RST)
      LOCK_IN && moved_r && GAIN_CONTROL_LEVEL == 6'h3F |=> track_r)
      else $error("tracking flag dropped at gain extreme");
   AST_EXT_BIT_TIME: assert property (@(posedge LINK_CLK) disable iff (!CS || link_rst)
      st_r == L_RDATA && ext_l && slot_r != `OPS_EXT_LAST_SLOT |=> $stable(DIO_OUT))
      else $error("extended read bit shorter than four clocks");
   AST_PROBE_FIRST: assert property (@(posedge LINK_CLK) disable iff (!CS || link_rst)
      st_r == L_CMD && st_nxt == L_PROBE |=> FUSE_SUPPLY_PIN_OE
      && FUSE_SUPPLY_PIN_OUT == ~$past(ls_fuse_r[61]))
      else $error("probe did not start with the top fuse");
   COV_EXT: cover property (@(posedge CLK) req_new && xfer_cmd_r == `OPS_CMD_EXT_ENTER);
   COV_WRITE: cover property (@(posedge CLK) req_new && ext_r && xfer_cmd_r == `OPS_CMD_SOFT_WRITE);
   COV_BURN: cover property (@(posedge CLK) req_new && ext_r && hv_s && xfer_cmd_r == `OPS_CMD_BURN);
   COV_PROBE: cover property (@(posedge LINK_CLK) st_r == L_PROBE && cnt_r == `OPS_PROBE_LAST);
endmodule // ops_core

// *** sim/ops_host.sv ***
`timescale 1ns/1ps
// host model: clocks the link inside frames and in idle pulses with select low, link clock rests low between pulses
module ops_host
   import ops_pkg::*;
   (
   // serial link toward the device
   output logic link_clk,
   output logic cs,
   output logic dio_in,
   // device answers
   input wire logic dio_out,
   input wire logic dio_oe,
   input wire logic pin_out,
   input wire logic pin_oe
   );
   logic hd; // level the host puts on the data line
   // wire level: device wins while it drives; a released host keeps toggling
   // so a stale value never passes for an answer
   assign dio_in = dio_oe ? dio_out : hd;
   initial
   begin
      link_clk = 1'b0;
      cs = 1'b0;
      hd = 1'b0;
   end
   // clock pulses with select low, for reset and snapshot refresh
   task idle(input int n);
      repeat (n)
      begin
         hd = ~hd;
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
      end
   endtask
   // one frame: command, nw write bits, nr read bits, slot clocks per bit
   task frame(input ops_cmd_t cmd, input logic [20:0] wd, input int nw, input int nr,
      input int slot, input logic probe, output logic [63:0] rd);
      int n;
      int r;
      int k;
      n = 5 + (nw + nr) * slot;
      rd = '0;
      cs = 1'b1;
      for (r = 1; r <= n; r++)
      begin
         // data set in the low phase, held across the rise
         if (r <= 5)
            hd = cmd[5 - r];
         else if (r <= 5 + nw * slot)
            hd = wd[20 - (r - 6) / slot];
         else
            hd = ~hd;
         #80 link_clk = 1'b1;
         #40;
         k = (r - 5) / slot;
         // read bit taken late in its slot; unknown if nobody drives
         if (nw == 0 && r >= 5 && (r - 5) % slot == slot - 1 && k < nr)
         begin
            if (probe)
               rd[nr - 1 - k] = pin_oe ? pin_out : 1'bx;
            else
               rd[nr - 1 - k] = dio_oe ? dio_out : 1'bx;
         end
         #40 link_clk = 1'b0;
      end
      cs = 1'b0;
      idle(4);
   endtask
endmodule // ops_host

// *** sim/ops_core_tb.sv ***
`timescale 1ns/1ps
`include "ops_map.svh"
module ops_core_tb
   import ops_pkg::*;
   ;
   logic clk, sys_rst, fuse_ok, lock; // bench-driven inputs
   logic [5:0] gain;
   logic [8:0] angle;
   wire link_clk, cs, dio_in, dio_out, dio_oe, pin_out, pin_oe; // link wires
   wire [8:0] zero;
   wire [2:0] pole;
   wire [1:0] inc, sens;
   wire track, ext, ferr;
   int err_count, total_checks, cycles, slot, a, s;
   logic [63:0] rd; // last serial answer
   logic [20:0] w; // word under test
   ops_core DUT (.CLK(clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk), .CS(cs),
      .DIO_IN(dio_in), .DIO_OUT(dio_out), .DIO_OE(dio_oe), .FUSE_SUPPLY_OK(fuse_ok),
      .FUSE_SUPPLY_PIN_OUT(pin_out), .FUSE_SUPPLY_PIN_OE(pin_oe), .LOCK_IN(lock),
      .GAIN_CONTROL_LEVEL(gain), .ANGLE_IN(angle), .ZERO_OFFSET_FIELD(zero),
      .POLE_SEL(pole), .INC_MODE(inc), .GAIN_SENS(sens), .TRACK_VALID(track),
      .EXT_MODE(ext), .FUSE_ERR(ferr));
   ops_host host (.link_clk(link_clk), .cs(cs), .dio_in(dio_in), .dio_out(dio_out),
      .dio_oe(dio_oe), .pin_out(pin_out), .pin_oe(pin_oe));
   // 40 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, well above the expected run length
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_count++;
         conclude();
      end
   end
   task conclude();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // front-end and supply inputs change just after a clock edge, then settle;
   // the link only refreshes its status copy on its own clock, so idle it
   // long enough for two snapshot round trips before any serial read
   task set_in(input logic l, input logic [5:0] g, input logic [8:0] an, input logic f);
      @(posedge clk);
      #1;
      lock = l;
      gain = g;
      angle = an;
      fuse_ok = f;
      repeat (8) @(posedge clk);
      #1;
      host.idle(8);
   endtask
   // spare bit forces the addressed bit of the applied word to one; the working word keeps it
   function automatic logic [20:0] fix(input logic [20:0] v);
      if (v[`OPS_SPARE_BIT])
         v[v[`OPS_SPARE_ADDR_MSB:`OPS_SPARE_ADDR_LSB]] = 1'b1;
      return v;
   endfunction
   task chk_fields(input logic [20:0] v);
      logic [20:0] f;
      f = fix(v);
      chk("zero", f[`OPS_ZERO_MSB:`OPS_ZERO_LSB], zero);
      chk("pole", f[`OPS_POLE_MSB:`OPS_POLE_LSB], pole);
      chk("inc", f[`OPS_INC_MSB:`OPS_INC_LSB], inc);
      chk("sens", f[`OPS_SENS_MSB:`OPS_SENS_LSB], sens);
   endtask
   task xf(input ops_cmd_t c, input logic [20:0] d, input int nw, input int nr,
      input logic p);
      host.frame(c, d, nw, nr, p ? 1 : slot, p, rd);
   endtask
   initial
   begin
      sys_rst = 1'b1;
      fuse_ok = 1'b0;
      lock = 1'b0;
      gain = 6'h20; // mid-range level a host aims for
      angle = 9'h000;
      err_count = 0;
      total_checks = 0;
      cycles = 0;
      slot = 1;
      // reset long enough for both domains, link clocked with select low
      host.idle(3);
      @(posedge clk);
      #1 sys_rst = 1'b0;
      host.idle(4);
      chk_fields(21'h0_0000);
      chk("ext", 1'h0, ext);
      chk("ferr", 1'h0, ferr);
      // soft write before extended mode is ignored
      xf(`OPS_CMD_SOFT_WRITE, 21'h0_C1A5, 21, 0, 1'b0);
      chk_fields(21'h0_0000);
      // locked but magnet not yet moved
      set_in(1'b1, 6'h3F, 9'h000, 1'b0);
      chk("track", 1'h0, track);
      set_in(1'b1, 6'h3F, 9'h003, 1'b0);
      chk("track", 1'h1, track);
      xf(`OPS_CMD_READ_ANGLE, 21'h0_0000, 0, 16, 1'b0);
      chk("angle", {1'h1, 6'h3F, 9'h003}, rd);
      set_in(1'b1, 6'h00, 9'h003, 1'b0);
      chk("track", 1'h1, track);
      set_in(1'b0, 6'h00, 9'h003, 1'b0);
      chk("track", 1'h0, track);
      xf(`OPS_CMD_READ_ANGLE, 21'h0_0000, 0, 16, 1'b0);
      chk("angle", {1'h0, 6'h00, 9'h003}, rd);
      // extended mode, four clocks per bit from here on, one clock per fuse in the probe
      xf(`OPS_CMD_EXT_ENTER, 21'h0_0000, 0, 0, 1'b0);
      slot = 4;
      chk("ext", 1'h1, ext);
      // every sensitivity step through soft write
      for (s = 0; s < 4; s++)
      begin
         w = {4'h0, 1'h0, s[1:0], 2'h2, 3'h5, 9'h1A5 ^ s[8:0]};
         xf(`OPS_CMD_SOFT_WRITE, w, 21, 0, 1'b0);
         chk_fields(w);
      end
      xf(`OPS_CMD_READ_FUSE, 21'h0_0000, 0, 21, 1'b0);
      chk("readback", w, rd);
      // spare bit at every address of the customer region
      for (a = 0; a < 16; a++)
      begin
         w = {a[3:0], 1'h1, 16'h0000};
         xf(`OPS_CMD_SOFT_WRITE, w, 21, 0, 1'b0);
         chk_fields(w);
      end
      // burn without programming supply fails and is flagged
      w = {4'h0, 1'h0, 2'h2, 2'h1, 3'h3, 9'h0C7};
      xf(`OPS_CMD_BURN, w, 21, 0, 1'b0);
      chk("ferr", 1'h1, ferr);
      xf(`OPS_CMD_STATUS, 21'h0_0000, 0, 1, 1'b0);
      chk("status", 1'h1, rd);
      set_in(1'b0, 6'h00, 9'h003, 1'b1);
      xf(`OPS_CMD_BURN, w, 21, 0, 1'b0);
      chk("ferr", 1'h0, ferr);
      chk_fields(w);
      xf(`OPS_CMD_STATUS, 21'h0_0000, 0, 1, 1'b0);
      chk("status", 1'h0, rd);
      xf(`OPS_CMD_READ_FUSE, 21'h0_0000, 0, 21, 1'b0);
      chk("readback", w, rd);
      // probe: top fuse bit first, low level marks a programmed fuse
      xf(`OPS_CMD_PROBE, 21'h0_0000, 0, 62, 1'b1);
      chk("probe", {2'h0, ~{`OPS_FACTORY_DEFAULT, w}}, rd);
      // fuses only gain bits, so clearing one cannot be burned
      xf(`OPS_CMD_BURN, w ^ 21'h0_0001, 21, 0, 1'b0);
      chk("ferr", 1'h1, ferr);
      xf(`OPS_CMD_READ_FUSE, 21'h0_0000, 0, 21, 1'b0);
      chk("readback", w, rd);
      conclude();
   end
endmodule // ops_core_tb
